// file: design/sf_sync_pkg.sv
package sf_sync_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int BITS_PER_FRAME   = 193;
  localparam int FRAMES_PER_SF    = 12;
  localparam int WINDOW_DEPTH     = (FRAMES_PER_SF - 1) * BITS_PER_FRAME;
  localparam int CONFIRM_FRAMES   = 12;
  localparam int J1_FREE_FRAME    = 11;
  localparam int OOF_ERR_LIMIT    = 2;
  localparam int OOF_HIST_W       = 6;
  localparam logic [11:0] SF_PATTERN = 12'h8DC;

  //////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_ERR_COUNT = 8'h08;

  localparam int ST_OOF       = 0;
  localparam int ST_MIMIC     = 1;
  localparam int ST_MF        = 2;
  localparam int ST_FERR      = 3;
  localparam int ST_OOF_EVENT = 4;
  localparam int ST_FRAME_LSB = 8;
  localparam int ERR_COUNT_W  = 16;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    FMT_SF    = 2'h0,
    FMT_ESF   = 2'h1,
    FMT_DM    = 2'h2,
    FMT_SLC96 = 2'h3
  } format_t;

  typedef struct packed {
    logic [1:0] oof_criterion;
    format_t    format;
    logic       j1_mode;
    logic       mimic_check_select;
    logic       framer_bypass;
  } ctrl_t;

  localparam ctrl_t CONTROL_RESET = 7'h00;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_HUNT,
    ST_CONFIRM,
    ST_LOCKED
  } sync_state_t;

endpackage : sf_sync_pkg

// file: design/t1_j1_superframe_sync.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module t1_j1_superframe_sync (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // register port
  input  wire sf_sync_pkg::bus_req_t bus_req,
  output logic [31:0]               rdata,
  // received stream from the line decoder
  input  wire logic                 rx_bit,
  input  wire logic                 rx_bit_valid,
  // status outputs
  output logic                      out_of_frame_status,
  output logic                      mimic_seen_flag,
  output logic                      multiframe_boundary_flag,
  output logic                      framing_bit_error,
  output logic                      oof_event
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  sf_sync_pkg::ctrl_t       ctrl;
  sf_sync_pkg::sync_state_t state;
  logic [sf_sync_pkg::WINDOW_DEPTH-1:0] window_sr;
  logic [11:0]              col;
  logic [11:0]              match;
  logic [11:0]              fill_cnt;
  logic                     hist_full;
  logic                     any_match;
  logic [3:0]               match_frame;
  logic [7:0]               bit_pos;
  logic [3:0]               frame_idx;
  logic [3:0]               next_frame;
  logic [3:0]               good_cnt;
  logic                     mimic_hit;
  logic                     search_on;
  logic                     f_bit;
  logic                     fbit_bad;
  logic [sf_sync_pkg::OOF_HIST_W-1:0] err_hist;
  logic [3:0]               err_sum;
  logic                     oof_declare;
  logic                     mimic_now;
  logic                     mf_now;
  logic                     ferr_now;
  logic                     sticky_mf;
  logic                     sticky_ferr;
  logic                     sticky_oof;
  logic [sf_sync_pkg::ERR_COUNT_W-1:0] err_count;
  logic                     wr_ctrl;
  logic                     wr_status;
  logic                     wr_count;

  //////////////////////////////////////////////////////////////////////////////
  // format and bypass gating
  always_comb begin
    search_on = 1'b0;
    if (!ctrl.framer_bypass) begin
      case (ctrl.format)
        sf_sync_pkg::FMT_SF: search_on = 1'b1;
        sf_sync_pkg::FMT_DM: search_on = !ctrl.j1_mode;
        default:             search_on = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // eleven-frame bit history
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      window_sr <= '0;
    end else if (rx_bit_valid) begin
      window_sr <= {window_sr[sf_sync_pkg::WINDOW_DEPTH-2:0], rx_bit};
    end
  end

  // history fill count, no match on bits never received
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fill_cnt <= 12'h000;
    end else if (rx_bit_valid && (fill_cnt != 12'(sf_sync_pkg::WINDOW_DEPTH))) begin
      fill_cnt <= fill_cnt + 12'h001;
    end
  end

  // column of one bit position over the last twelve frames
  always_comb begin
    col[0] = rx_bit;
    for (int k = 1; k < sf_sync_pkg::FRAMES_PER_SF; k++) begin
      col[k] = window_sr[k*sf_sync_pkg::BITS_PER_FRAME-1];
    end
  end

  // match of the column against each frame phase of the pattern
  always_comb begin
    int idx;
    idx = 0;
    for (int f = 0; f < sf_sync_pkg::FRAMES_PER_SF; f++) begin
      match[f] = 1'b1;
      for (int k = 0; k < sf_sync_pkg::FRAMES_PER_SF; k++) begin
        idx = (f - k + sf_sync_pkg::FRAMES_PER_SF) % sf_sync_pkg::FRAMES_PER_SF;
        if (!(ctrl.j1_mode && idx == sf_sync_pkg::J1_FREE_FRAME) &&
            col[k] != sf_sync_pkg::SF_PATTERN[11-idx]) begin
          match[f] = 1'b0;
        end
      end
    end
  end

  always_comb begin
    hist_full   = (fill_cnt == 12'(sf_sync_pkg::WINDOW_DEPTH));
    any_match   = hist_full && (|match);
    match_frame = 4'h0;
    for (int f = sf_sync_pkg::FRAMES_PER_SF - 1; f >= 0; f--) begin
      if (match[f]) begin
        match_frame = 4'(f);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // overhead bit check
  always_comb begin
    int nf;
    nf         = (frame_idx == 4'hB) ? 0 : int'(frame_idx) + 1;
    next_frame = 4'(nf);
    f_bit      = rx_bit_valid && (bit_pos == 8'h00) && (state != sf_sync_pkg::ST_HUNT);
    fbit_bad   = (rx_bit != sf_sync_pkg::SF_PATTERN[11-nf]) &&
                 !(ctrl.j1_mode && nf == sf_sync_pkg::J1_FREE_FRAME);
    mimic_now  = rx_bit_valid && any_match && (bit_pos != 8'h00) &&
                 (state == sf_sync_pkg::ST_CONFIRM);
  end

  // error density over the last overhead bits
  always_comb begin
    int win;
    win = 4;
    case (ctrl.oof_criterion)
      2'h1:    win = 5;
      2'h2:    win = 6;
      default: win = 4;
    endcase
    err_sum = {3'h0, fbit_bad};
    for (int i = 0; i < sf_sync_pkg::OOF_HIST_W; i++) begin
      if (i < win - 1) begin
        err_sum = err_sum + {3'h0, err_hist[i]};
      end
    end
    oof_declare = f_bit && (state == sf_sync_pkg::ST_LOCKED) &&
                  (err_sum >= 4'(sf_sync_pkg::OOF_ERR_LIMIT));
    ferr_now    = f_bit && (state == sf_sync_pkg::ST_LOCKED) && fbit_bad;
    mf_now      = f_bit && (state == sf_sync_pkg::ST_LOCKED) && (next_frame == 4'h0) &&
                  !oof_declare;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit and frame counters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bit_pos   <= 8'h00;
      frame_idx <= 4'h0;
    end else if (rx_bit_valid) begin
      if (state == sf_sync_pkg::ST_HUNT) begin
        bit_pos   <= 8'h01;
        frame_idx <= match_frame;
      end else begin
        bit_pos   <= (bit_pos == 8'(sf_sync_pkg::BITS_PER_FRAME - 1)) ? 8'h00 :
                     bit_pos + 8'h01;
        if (f_bit) begin
          frame_idx <= next_frame;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronisation state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state     <= sf_sync_pkg::ST_HUNT;
      good_cnt  <= 4'h0;
      mimic_hit <= 1'b0;
    end else if (!search_on) begin
      state     <= sf_sync_pkg::ST_HUNT;
      good_cnt  <= 4'h0;
      mimic_hit <= 1'b0;
    end else if (rx_bit_valid) begin
      case (state)
        sf_sync_pkg::ST_HUNT: begin
          good_cnt  <= 4'h0;
          mimic_hit <= 1'b0;
          if (any_match) begin
            state <= sf_sync_pkg::ST_CONFIRM;
          end
        end
        sf_sync_pkg::ST_CONFIRM: begin
          if (mimic_now) begin
            mimic_hit <= 1'b1;
          end
          if (f_bit) begin
            if (fbit_bad) begin
              state <= sf_sync_pkg::ST_HUNT;
            end else if (good_cnt == 4'(sf_sync_pkg::CONFIRM_FRAMES - 1)) begin
              if (ctrl.mimic_check_select && mimic_hit) begin
                state <= sf_sync_pkg::ST_HUNT;
              end else begin
                state <= sf_sync_pkg::ST_LOCKED;
              end
            end else begin
              good_cnt <= good_cnt + 4'h1;
            end
          end
        end
        sf_sync_pkg::ST_LOCKED: begin
          if (oof_declare) begin
            state <= sf_sync_pkg::ST_HUNT;
          end
        end
        default: state <= sf_sync_pkg::ST_HUNT;
      endcase
    end
  end

  // overhead error history
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      err_hist <= '0;
    end else if (state != sf_sync_pkg::ST_LOCKED) begin
      err_hist <= '0;
    end else if (f_bit) begin
      err_hist <= {err_hist[sf_sync_pkg::OOF_HIST_W-2:0], fbit_bad};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_of_frame_status      <= 1'b1;
      multiframe_boundary_flag <= 1'b0;
      framing_bit_error        <= 1'b0;
      oof_event                <= 1'b0;
    end else begin
      if (!search_on || oof_declare) begin
        out_of_frame_status <= 1'b1;
      end else if (rx_bit_valid && f_bit && state == sf_sync_pkg::ST_CONFIRM && !fbit_bad &&
                   good_cnt == 4'(sf_sync_pkg::CONFIRM_FRAMES - 1) &&
                   !(ctrl.mimic_check_select && mimic_hit)) begin
        out_of_frame_status <= 1'b0;
      end
      multiframe_boundary_flag <= search_on && mf_now;
      framing_bit_error        <= search_on && ferr_now;
      oof_event                <= search_on && oof_declare;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port
  always_comb begin
    wr_ctrl   = bus_req.wr && (bus_req.addr == sf_sync_pkg::ADDR_CONTROL);
    wr_status = bus_req.wr && (bus_req.addr == sf_sync_pkg::ADDR_STATUS);
    wr_count  = bus_req.wr && (bus_req.addr == sf_sync_pkg::ADDR_ERR_COUNT);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl <= sf_sync_pkg::CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= bus_req.wdata[$bits(sf_sync_pkg::ctrl_t)-1:0];
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mimic_seen_flag <= 1'b0;
      sticky_mf       <= 1'b0;
      sticky_ferr     <= 1'b0;
      sticky_oof      <= 1'b0;
    end else begin
      if (search_on && mimic_now) begin
        mimic_seen_flag <= 1'b1;
      end else if (wr_status && bus_req.wdata[sf_sync_pkg::ST_MIMIC]) begin
        mimic_seen_flag <= 1'b0;
      end
      if (search_on && mf_now) begin
        sticky_mf <= 1'b1;
      end else if (wr_status && bus_req.wdata[sf_sync_pkg::ST_MF]) begin
        sticky_mf <= 1'b0;
      end
      if (search_on && ferr_now) begin
        sticky_ferr <= 1'b1;
      end else if (wr_status && bus_req.wdata[sf_sync_pkg::ST_FERR]) begin
        sticky_ferr <= 1'b0;
      end
      if (search_on && oof_declare) begin
        sticky_oof <= 1'b1;
      end else if (wr_status && bus_req.wdata[sf_sync_pkg::ST_OOF_EVENT]) begin
        sticky_oof <= 1'b0;
      end
    end
  end

  // saturating framing error count, any write clears, an error wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      err_count <= '0;
    end else if (search_on && ferr_now) begin
      if (err_count != '1) begin
        err_count <= err_count + {{(sf_sync_pkg::ERR_COUNT_W-1){1'b0}}, 1'b1};
      end
    end else if (wr_count) begin
      err_count <= '0;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          sf_sync_pkg::ADDR_CONTROL: begin
            rdata[$bits(sf_sync_pkg::ctrl_t)-1:0] <= ctrl;
          end
          sf_sync_pkg::ADDR_STATUS: begin
            rdata[sf_sync_pkg::ST_OOF]       <= out_of_frame_status;
            rdata[sf_sync_pkg::ST_MIMIC]     <= mimic_seen_flag;
            rdata[sf_sync_pkg::ST_MF]        <= sticky_mf;
            rdata[sf_sync_pkg::ST_FERR]      <= sticky_ferr;
            rdata[sf_sync_pkg::ST_OOF_EVENT] <= sticky_oof;
            rdata[sf_sync_pkg::ST_FRAME_LSB +: 4] <= frame_idx;
          end
          sf_sync_pkg::ADDR_ERR_COUNT: begin
            rdata[sf_sync_pkg::ERR_COUNT_W-1:0] <= err_count;
          end
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : t1_j1_superframe_sync

// file: bench/sf_sync_chk.sv
`timescale 1ns/1ps
module sf_sync_chk (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  reset,
  // register port
  input wire sf_sync_pkg::bus_req_t bus_req,
  input wire logic [31:0]           rdata,
  // stream and status
  input wire logic                  rx_bit,
  input wire logic                  rx_bit_valid,
  input wire logic                  out_of_frame_status,
  input wire logic                  mimic_seen_flag,
  input wire logic                  multiframe_boundary_flag,
  input wire logic                  framing_bit_error,
  input wire logic                  oof_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // bits taken since the last boundary pulse
  logic [11:0] bits;
  logic        armed;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bits <= 12'h000;
      armed <= 1'b0;
    end else begin
      armed <= multiframe_boundary_flag | (armed & ~out_of_frame_status);
      if (multiframe_boundary_flag) bits <= {11'h000, rx_bit_valid};
      else if (rx_bit_valid) bits <= bits + 12'h001;
    end
  end
  sequence s_hunt_hold;
    out_of_frame_status [*8];
  endsequence
  a_restart_hunt:
    assert property (oof_event |-> s_hunt_hold) else $error("status low after oof");
  a_oof_locked:
    assert property (oof_event |-> !$past(out_of_frame_status)) else $error("oof unlocked");
  a_error_locked:
    assert property (framing_bit_error |-> !$past(out_of_frame_status))
    else $error("framing error unlocked");
  a_boundary_locked:
    assert property (multiframe_boundary_flag |-> !$past(out_of_frame_status))
    else $error("boundary unlocked");
  a_boundary_spacing:
    assert property (multiframe_boundary_flag && armed |-> bits == 12'h90C)
    else $error("superframe length wrong");
  a_lock_on_bit:
    assert property ($fell(out_of_frame_status) |-> $past(rx_bit_valid))
    else $error("lock without a bit");
  a_mimic_sticky:
    assert property ($fell(mimic_seen_flag) |-> $past(bus_req.wr) && $past(bus_req.wdata[1])
      && $past(bus_req.addr) == sf_sync_pkg::ADDR_STATUS) else $error("mimic flag lost");
  a_read_idle:
    assert property (!$past(bus_req.rd) |-> rdata == 32'h0) else $error("rdata not idle");
endmodule : sf_sync_chk
bind t1_j1_superframe_sync sf_sync_chk i_sf_sync_chk (
  .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
  .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
  .out_of_frame_status(out_of_frame_status), .mimic_seen_flag(mimic_seen_flag),
  .multiframe_boundary_flag(multiframe_boundary_flag),
  .framing_bit_error(framing_bit_error), .oof_event(oof_event));

// file: bench/line_src.sv
`timescale 1ns/1ps
module line_src (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // scenario controls
  input  wire logic j1_x,
  input  wire logic slow,
  input  wire logic corrupt,
  input  wire logic mimic_en,
  // decoded stream
  output logic      rx_bit,
  output logic      rx_bit_valid
);
  logic [7:0] pos;
  logic [3:0] frame;
  logic       gap;
  logic       fbit;
  // overhead bit in frame order, frame 12 bit set by the bench
  assign fbit = (frame == 4'hB) ? j1_x
              : sf_sync_pkg::SF_PATTERN[4'hB - frame];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pos <= 8'h00;
      frame <= 4'h0;
      gap <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else begin
      gap <= slow & ~gap;
      rx_bit_valid <= ~gap;
      if (gap) begin
        rx_bit <= ~rx_bit;
      end else begin
        rx_bit <= (pos == 8'h00) ? fbit ^ corrupt
                : mimic_en & fbit & (pos == 8'h61);
        pos <= (pos == 8'hC0) ? 8'h00 : pos + 8'h01;
        if (pos == 8'hC0) frame <= (frame == 4'hB) ? 4'h0 : frame + 4'h1;
      end
    end
  end
endmodule : line_src

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  sf_sync_pkg::bus_req_t bus_req = '0;
  logic [31:0]           rdata;
  logic rx_bit, rx_bit_valid, oof_st, mimic, mfb, ferr, oofe;
  logic j1_x = 1'b0, slow = 1'b0, corrupt = 1'b0, mimic_en = 1'b0;
  int n_errors = 0, comparisons = 0, n_ferr = 0, n_oof = 0, n_mf = 0;
  logic [6:0] t_ctl [9] = '{7'h00, 7'h00, 7'h00, 7'h04, 7'h08, 7'h10, 7'h14, 7'h18, 7'h01};
  // frame 12 bit, slow stream, lock expected
  logic [2:0] t_opt [9] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (ferr === 1'b1) n_ferr++;
    if (oofe === 1'b1) n_oof++;
    if (mfb === 1'b1) n_mf++;
  end
  t1_j1_superframe_sync i_t1_j1_superframe_sync (
    .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .out_of_frame_status(oof_st),
    .mimic_seen_flag(mimic), .multiframe_boundary_flag(mfb),
    .framing_bit_error(ferr), .oof_event(oofe));
  line_src i_line_src (
    .mclk(mclk), .reset(reset), .j1_x(j1_x), .slow(slow), .corrupt(corrupt),
    .mimic_en(mimic_en), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) @(posedge mclk);
  endtask : run
  task automatic rst();
    run(1);
    reset <= 1'b1;
    run(4);
    reset <= 1'b0;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    run(1);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    run(1);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    run(1);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    run(1);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata & m, e);
  endtask : rd
  task automatic hunt(input int bnd, input logic lk, input int mn);
    int t;
    t = 0;
    while (oof_st !== 1'b0 && t < bnd) begin
      @(negedge mclk);
      t++;
    end
    chk({31'h0, oof_st}, {31'h0, !lk});
    if (lk) chk(t >= mn, 1);
    if (lk && t >= bnd) results();
    if (!lk) chk(n_mf, 0);
  endtask : hunt
  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    rst();
    rd(sf_sync_pkg::ADDR_CONTROL, 32'hFFFFFFFF, 32'h0);
    rd(sf_sync_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 9; i++) begin
      {j1_x, slow} <= t_opt[i][2:1];
      rst();
      n_mf = 0;
      wr(sf_sync_pkg::ADDR_CONTROL, {25'h0, t_ctl[i]});
      hunt(26 * 193 * (1 + slow), t_opt[i][0], 23 * 193 * (1 + slow));
    end
    rst();
    hunt(26 * 193, 1'b1, 23 * 193);
    run(1);
    corrupt <= 1'b1;
    run(193);
    corrupt <= 1'b0;
    run(14 * 193);
    chk(n_ferr, 1);
    chk(n_mf, 2);
    rd(sf_sync_pkg::ADDR_ERR_COUNT, 32'hFFFFFFFF, 32'h1);
    wr(sf_sync_pkg::ADDR_ERR_COUNT, 32'h0);
    rd(sf_sync_pkg::ADDR_ERR_COUNT, 32'hFFFFFFFF, 32'h0);
    corrupt <= 1'b1;
    run(386);
    corrupt <= 1'b0;
    run(10);
    chk(n_oof, 1);
    chk({31'h0, oof_st}, 32'h1);
    rd(sf_sync_pkg::ADDR_ERR_COUNT, 32'hFFFFFFFF, 32'h2);
    rd(sf_sync_pkg::ADDR_STATUS, 32'h1F, 32'h1D);
    wr(sf_sync_pkg::ADDR_STATUS, 32'h1E);
    rd(sf_sync_pkg::ADDR_STATUS, 32'h1F, 32'h01);
    mimic_en <= 1'b1;
    rst();
    n_mf = 0;
    wr(sf_sync_pkg::ADDR_CONTROL, 32'h2);
    hunt(26 * 193, 1'b0, 0);
    chk({31'h0, mimic}, 32'h1);
    wr(sf_sync_pkg::ADDR_CONTROL, 32'h0);
    hunt(50 * 193, 1'b1, 0);
    wr(sf_sync_pkg::ADDR_STATUS, 32'h2);
    rd(sf_sync_pkg::ADDR_STATUS, 32'h2, 32'h0);
    results();
  end
endmodule : tb
